// [rtl/low_power_sniff_config_regs.sv]
// Purpose: Text-command register bank for low-power mode, sniff timing and serial format.
// Assumes: rxData/rxValid deliver one received command byte per pulse; txReady back-pressures replies.
// Notes:   Accepts ATSnnn=v<CR>, ATSnnn?<CR> and AT&F<CR>, upper case only.
// How it works
// RQ1: Mode setting 0..3 selects none, hold, park or sniff power saving.
// RQ2: Mode setting 4 selects the user-programmed sniff parameters instead of built-in timing.
// RQ3: Sniff period holds the wake-up cycle in 625 us slots and resets to 800.
// RQ4: Sniff offset holds a value in 625 us slots and resets to 80.
// RQ5: The host keeps the offset at most the period minus two slots.
// RQ6: Sniff attempt gives the listen slots per wake-up, resets to 8, and stays below half the period.
// RQ7: Sniff timeout gives the extra listen slots per wake-up and resets to 8.
// RQ8: A local change of mode or sniff setting drops the link, a remote one does not.
// RQ9: A serial format change is answered in the old format and takes effect afterwards.
// RQ10: Factory restore returns the serial rate setting to 9600 bps.
// RQ11: A sniff write that breaks the offset or attempt limits is refused with an error reply.
`timescale 1ns/1ps
`default_nettype none
module low_power_sniff_config_regs
	import lp_sniff_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Received command bytes
	input  wire logic [7:0] rxData,
	input  wire logic       rxValid,
	input  wire logic       remoteCfg,
	// Reply bytes
	output var  logic [7:0] txData,
	output var  logic       txValid,
	input  wire logic       txReady,
	// Configuration outputs
	output var  lp_mode_t   lpMode,
	output var  logic       userSniff,
	output var  sniff_t     sniffCfg,
	output var  ser_fmt_t   serFmt,
	output var  logic       linkDrop
);

	typedef enum logic [2:0] {
		S_A    = 3'b000,
		S_T    = 3'b001,
		S_CMD  = 3'b010,
		S_NUM  = 3'b011,
		S_VAL  = 3'b100,
		S_EOL  = 3'b101,
		S_EXEC = 3'b110,
		S_SEND = 3'b111
	} state_t;

	state_t      state_r;
	cmd_t        cmd_r;
	logic [9:0]  regNum_r;
	logic [19:0] acc_r;
	logic        ovf_r;
	lp_mode_t    lpMode_r;
	sniff_t      sniff_r;
	ser_fmt_t    fmtStore_r;
	ser_fmt_t    fmtActive_r;
	logic        fmtPending_r;
	logic        drop_r;
	logic [7:0]  txBuf_r [BUF_LEN];
	logic [2:0]  txLen_r;
	logic [2:0]  txIdx_r;
	logic        txValid_r;

	logic        isDigit;
	logic [3:0]  digitVal;
	logic        okCmd;
	logic        doWrite;
	logic [15:0] rdVal;
	lp_mode_t    candMode;
	sniff_t      candSniff;
	ser_fmt_t    candFmt;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Offset and attempt limits against the period
	function automatic logic sniff_valid(input sniff_t s);
		logic offOk;
		logic attOk;
		offOk = (s.period >= OFFSET_GAP) && (s.offset <= s.period - OFFSET_GAP);
		// Compared doubled so that an odd period keeps its half slot
		attOk = {s.attempt, 1'b0} < {1'b0, s.period};
		return offOk && attOk;
	endfunction : sniff_valid

	// One decimal digit of a value as a character
	function automatic logic [7:0] dec_char(input logic [15:0] v, input int pos);
		logic [15:0] q;
		q = v;
		for (int i = 0; i < pos; i++) begin
			q = q / 16'd10;
		end
		return CH_0 + 8'(q % 16'd10);
	endfunction : dec_char

	// Number of decimal digits, at least one
	function automatic logic [2:0] dec_len(input logic [15:0] v);
		if (v >= 16'd10000) return 3'd5;
		if (v >= 16'd1000) return 3'd4;
		if (v >= 16'd100) return 3'd3;
		if (v >= 16'd10) return 3'd2;
		return 3'd1;
	endfunction : dec_len

	assign isDigit  = (rxData >= CH_0) && (rxData <= CH_9);
	assign digitVal = 4'(rxData - CH_0);

	////////////////////////////////////////////////////////////////////////
	// Command decode, valid only while state_r is S_EXEC
	always_comb begin
		okCmd     = 1'b0;
		doWrite   = 1'b0;
		rdVal     = 16'h0000;
		candMode  = lpMode_r;
		candSniff = sniff_r;
		candFmt   = fmtStore_r;
		unique case (cmd_r)
			CMD_RESTORE: begin
				okCmd = 1'b1;
			end
			CMD_READ: begin
				okCmd = 1'b1;
				case (regNum_r)
					REG_RATE:    rdVal = {12'h000, fmtStore_r.rate};
					REG_DLEN:    rdVal = {12'h000, fmtStore_r.dataLen};
					REG_PARITY:  rdVal = {12'h000, fmtStore_r.parity};
					REG_STOP:    rdVal = {12'h000, fmtStore_r.stopBits};
					REG_LPMODE:  rdVal = {13'h0000, lpMode_r};
					REG_PERIOD:  rdVal = sniff_r.period;
					REG_OFFSET:  rdVal = sniff_r.offset;
					REG_ATTEMPT: rdVal = sniff_r.attempt;
					REG_TIMEOUT: rdVal = sniff_r.timeout;
					default:     okCmd = 1'b0;
				endcase
			end
			CMD_WRITE: begin
				case (regNum_r)
					// RQ1: mode codes range
					REG_LPMODE: begin
						okCmd    = acc_r <= 20'(LP_USER);
						candMode = lp_mode_t'(acc_r[2:0]);
					end
					// RQ3: period in slots
					REG_PERIOD:  candSniff.period = acc_r[15:0];
					// RQ4: offset in slots
					REG_OFFSET:  candSniff.offset = acc_r[15:0];
					// RQ6: attempt slots
					REG_ATTEMPT: candSniff.attempt = acc_r[15:0];
					// RQ7: timeout slots
					REG_TIMEOUT: candSniff.timeout = acc_r[15:0];
					REG_RATE: begin
						okCmd        = (acc_r >= 20'(RATE_MIN)) && (acc_r <= 20'(RATE_MAX));
						candFmt.rate = acc_r[3:0];
					end
					REG_DLEN: begin
						okCmd           = acc_r == 20'(DLEN_RST);
						candFmt.dataLen = acc_r[3:0];
					end
					REG_PARITY: begin
						okCmd          = (acc_r != 20'h0_0000) && (acc_r <= 20'(PARITY_MAX));
						candFmt.parity = acc_r[3:0];
					end
					REG_STOP: begin
						okCmd            = (acc_r != 20'h0_0000) && (acc_r <= 20'(STOP_MAX));
						candFmt.stopBits = acc_r[3:0];
					end
					default: okCmd = 1'b0;
				endcase
				// RQ11: refuse bad sniff set
				if (regNum_r >= REG_PERIOD && regNum_r <= REG_TIMEOUT) begin
					okCmd = sniff_valid(candSniff);
				end
				// Values wider than 16 bits are refused, also when no digit followed the overflow
				okCmd   = okCmd && !ovf_r && (acc_r <= VAL_MAX);
				doWrite = okCmd;
			end
			CMD_BAD: okCmd = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Command parser
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r  <= S_A;
			cmd_r    <= CMD_BAD;
			regNum_r <= 10'h000;
			acc_r    <= 20'h0_0000;
			ovf_r    <= 1'b0;
		end else begin
			unique case (state_r)
				S_A: if (rxValid && rxData == CH_A) begin
					state_r <= S_T;
				end
				S_T: if (rxValid) begin
					state_r <= (rxData == CH_T) ? S_CMD : S_A;
				end
				S_CMD: if (rxValid) begin
					regNum_r <= 10'h000;
					acc_r    <= 20'h0_0000;
					ovf_r    <= 1'b0;
					if (rxData == CH_S) begin
						state_r <= S_NUM;
					end else if (rxData == CH_AMP) begin
						cmd_r   <= CMD_RESTORE;
						state_r <= S_EOL;
					end else if (rxData == CH_CR) begin
						cmd_r   <= CMD_BAD;
						state_r <= S_EXEC;
					end else begin
						cmd_r   <= CMD_BAD;
						state_r <= S_EOL;
					end
				end
				S_NUM: if (rxValid) begin
					if (isDigit) begin
						regNum_r <= 10'(regNum_r * 10'd10 + 10'(digitVal));
					end else if (rxData == CH_EQ) begin
						cmd_r   <= CMD_WRITE;
						state_r <= S_VAL;
					end else if (rxData == CH_QM) begin
						cmd_r   <= CMD_READ;
						state_r <= S_EOL;
					end else begin
						cmd_r   <= CMD_BAD;
						state_r <= (rxData == CH_CR) ? S_EXEC : S_EOL;
					end
				end
				S_VAL: if (rxValid) begin
					if (isDigit) begin
						// Wraps at 20 bits; a sticky overflow flag is set by the first digit after the value passes 16 bits, no later than any wrap
						acc_r <= 20'(acc_r * 20'd10 + 20'(digitVal));
						if (acc_r > VAL_MAX) ovf_r <= 1'b1;
					end else if (rxData == CH_CR) begin
						state_r <= S_EXEC;
					end else begin
						cmd_r   <= CMD_BAD;
						state_r <= S_EOL;
					end
				end
				S_EOL: if (rxValid) begin
					if (rxData == CH_CR) begin
						state_r <= S_EXEC;
					end else if (!(cmd_r == CMD_RESTORE && rxData == CH_F)) begin
						cmd_r <= CMD_BAD;
					end
				end
				S_EXEC: state_r <= S_SEND;
				S_SEND: if (txValid_r && txReady && txIdx_r == txLen_r - 3'd1) begin
					state_r <= S_A;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stored settings
	always_ff @(posedge clk) begin
		if (srst) begin
			lpMode_r   <= LP_NONE;
			sniff_r    <= SNIFF_RST;
			fmtStore_r <= FMT_RST;
		end else if (state_r == S_EXEC && cmd_r == CMD_RESTORE) begin
			lpMode_r   <= LP_NONE;
			sniff_r    <= SNIFF_RST;
			// RQ10: restore to 9600 bps
			fmtStore_r <= FMT_RST;
		end else if (state_r == S_EXEC && doWrite) begin
			// RQ2: user sniff set stored
			lpMode_r   <= candMode;
			sniff_r    <= candSniff;
			fmtStore_r <= candFmt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link drop on local low-power change; a restore that changes nothing keeps the link
	always_ff @(posedge clk) begin
		if (srst) begin
			drop_r <= 1'b0;
		end else begin
			drop_r <= 1'b0;
			if (state_r == S_EXEC && !remoteCfg) begin
				// RQ8: local change drops
				if (cmd_r == CMD_RESTORE) begin
					drop_r <= (lpMode_r != LP_NONE) || (sniff_r != SNIFF_RST);
				end else if (doWrite) begin
					drop_r <= (candMode != lpMode_r) || (candSniff != sniff_r);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Line format in force; held back until the reply has gone out in the old one
	always_ff @(posedge clk) begin
		if (srst) begin
			fmtActive_r  <= FMT_RST;
			fmtPending_r <= 1'b0;
		end else if (state_r == S_EXEC) begin
			fmtPending_r <= (cmd_r == CMD_RESTORE) || doWrite;
		end else if (state_r == S_SEND && txValid_r && txReady && txIdx_r == txLen_r - 3'd1) begin
			// RQ9: switch after reply
			if (fmtPending_r) fmtActive_r <= fmtStore_r;
			fmtPending_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reply builder and sender
	always_ff @(posedge clk) begin
		if (srst) begin
			txLen_r   <= 3'd0;
			txIdx_r   <= 3'd0;
			txValid_r <= 1'b0;
			for (int i = 0; i < BUF_LEN; i++) txBuf_r[i] <= 8'h00;
		end else if (state_r == S_EXEC) begin
			txIdx_r   <= 3'd0;
			txValid_r <= 1'b1;
			if (okCmd && cmd_r == CMD_READ) begin
				for (int i = 0; i < 5; i++) begin
					if (3'(i) < dec_len(rdVal)) txBuf_r[i] <= dec_char(rdVal, int'(dec_len(rdVal)) - 1 - i);
				end
				txBuf_r[dec_len(rdVal)]        <= CH_CR;
				txBuf_r[dec_len(rdVal) + 3'd1] <= CH_LF;
				txLen_r <= dec_len(rdVal) + 3'd2;
			end else if (okCmd) begin
				txBuf_r[0] <= CH_O;
				txBuf_r[1] <= CH_K;
				txBuf_r[2] <= CH_CR;
				txBuf_r[3] <= CH_LF;
				txLen_r    <= 3'd4;
			end else begin
				// RQ11: error reply
				txBuf_r[0] <= CH_E;
				txBuf_r[1] <= CH_R;
				txBuf_r[2] <= CH_R;
				txBuf_r[3] <= CH_O;
				txBuf_r[4] <= CH_R;
				txBuf_r[5] <= CH_CR;
				txBuf_r[6] <= CH_LF;
				txLen_r    <= 3'd7;
			end
		end else if (txValid_r && txReady) begin
			txIdx_r   <= txIdx_r + 3'd1;
			txValid_r <= txIdx_r != txLen_r - 3'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			txData    <= 8'h00;
			userSniff <= 1'b0;
		end else begin
			txData    <= (state_r == S_EXEC || (txValid_r && txReady)) ? 8'h00 : txBuf_r[txIdx_r];
			userSniff <= lpMode_r == LP_USER;
		end
	end

	assign txValid  = txValid_r;
	assign lpMode   = lpMode_r;
	assign sniffCfg = sniff_r;
	assign serFmt   = fmtActive_r;
	assign linkDrop = drop_r;

endmodule : low_power_sniff_config_regs
`default_nettype wire

// [rtl/lp_sniff_pkg.sv]
// Purpose: Shared constants and types for the low-power / sniff configuration bank.
// Assumes: Commands arrive as text bytes, already deserialised by the serial front end.
// Notes:   Register numbers are the decimal numbers used in the text commands.
package lp_sniff_pkg;

	// Text command register numbers
	localparam logic [9:0] REG_RATE    = 10'd210;
	localparam logic [9:0] REG_DLEN    = 10'd211;
	localparam logic [9:0] REG_PARITY  = 10'd212;
	localparam logic [9:0] REG_STOP    = 10'd213;
	localparam logic [9:0] REG_LPMODE  = 10'd230;
	localparam logic [9:0] REG_PERIOD  = 10'd231;
	localparam logic [9:0] REG_OFFSET  = 10'd232;
	localparam logic [9:0] REG_ATTEMPT = 10'd233;
	localparam logic [9:0] REG_TIMEOUT = 10'd234;

	// Reset / factory values
	localparam logic [7:0]  LPMODE_RST  = 8'h00;
	localparam logic [15:0] PERIOD_RST  = 16'h0320;
	localparam logic [15:0] OFFSET_RST  = 16'h0050;
	localparam logic [15:0] ATTEMPT_RST = 16'h0008;
	localparam logic [15:0] TIMEOUT_RST = 16'h0008;
	localparam logic [3:0]  RATE_RST    = 4'h4;
	localparam logic [3:0]  DLEN_RST    = 4'h8;
	localparam logic [3:0]  PARITY_RST  = 4'h1;
	localparam logic [3:0]  STOP_RST    = 4'h1;

	// Legal ranges of the serial format codes
	localparam logic [3:0] RATE_MIN   = 4'h4;
	localparam logic [3:0] RATE_MAX   = 4'h8;
	localparam logic [3:0] PARITY_MAX = 4'h3;
	localparam logic [3:0] STOP_MAX   = 4'h2;

	// Sniff timing unit in microseconds (one radio slot)
	localparam int SLOT_US = 625;
	// Least distance between offset and period, in slots
	localparam logic [15:0] OFFSET_GAP = 16'h0002;

	// Characters
	localparam logic [7:0] CH_A   = 8'h41;
	localparam logic [7:0] CH_T   = 8'h54;
	localparam logic [7:0] CH_S   = 8'h53;
	localparam logic [7:0] CH_F   = 8'h46;
	localparam logic [7:0] CH_K   = 8'h4B;
	localparam logic [7:0] CH_O   = 8'h4F;
	localparam logic [7:0] CH_E   = 8'h45;
	localparam logic [7:0] CH_R   = 8'h52;
	localparam logic [7:0] CH_AMP = 8'h26;
	localparam logic [7:0] CH_EQ  = 8'h3D;
	localparam logic [7:0] CH_QM  = 8'h3F;
	localparam logic [7:0] CH_CR  = 8'h0D;
	localparam logic [7:0] CH_LF  = 8'h0A;
	localparam logic [7:0] CH_0   = 8'h30;
	localparam logic [7:0] CH_9   = 8'h39;

	localparam logic [19:0] VAL_MAX = 20'h0_FFFF;
	localparam int          BUF_LEN = 8;

	typedef enum logic [2:0] {
		LP_NONE  = 3'b000,
		LP_HOLD  = 3'b001,
		LP_PARK  = 3'b010,
		LP_SNIFF = 3'b011,
		LP_USER  = 3'b100
	} lp_mode_t;

	typedef enum logic [1:0] {
		CMD_WRITE   = 2'b00,
		CMD_READ    = 2'b01,
		CMD_RESTORE = 2'b10,
		CMD_BAD     = 2'b11
	} cmd_t;

	typedef struct packed {
		logic [15:0] period;
		logic [15:0] offset;
		logic [15:0] attempt;
		logic [15:0] timeout;
	} sniff_t;

	typedef struct packed {
		logic [3:0] rate;
		logic [3:0] dataLen;
		logic [3:0] parity;
		logic [3:0] stopBits;
	} ser_fmt_t;

	localparam sniff_t   SNIFF_RST = '{PERIOD_RST, OFFSET_RST, ATTEMPT_RST, TIMEOUT_RST};
	localparam ser_fmt_t FMT_RST   = '{RATE_RST, DLEN_RST, PARITY_RST, STOP_RST};

endpackage : lp_sniff_pkg

// [verification/lp_sniff_assertions.sv]
// Purpose: Port-level checks of the low-power and sniff configuration bank.
// Assumes: One clock domain; srst synchronous active high.
// Notes:   Bound to the design from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module lp_sniff_assertions
	import lp_sniff_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       srst,
	// Command and reply bytes
	input wire logic [7:0] rxData,
	input wire logic       rxValid,
	input wire logic       remoteCfg,
	input wire logic [7:0] txData,
	input wire logic       txValid,
	input wire logic       txReady,
	// Configuration outputs
	input wire lp_mode_t   lpMode,
	input wire logic       userSniff,
	input wire sniff_t     sniffCfg,
	input wire ser_fmt_t   serFmt,
	input wire logic       linkDrop
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	////////////////////////////////////////
	// Reply offered but not yet taken, and a config move
	sequence s_offer;
		txValid && !txReady;
	endsequence
	sequence s_cfg_move;
		$changed(lpMode) || $changed(sniffCfg);
	endsequence

	////////////////////////////////////////
	a_mode_range: assert property (lpMode <= LP_USER)
		else $error("mode setting out of range");
	a_user_flag: assert property ((lpMode == LP_USER) |=> userSniff)
		else $error("user sniff flag missing");
	a_user_clear: assert property ((lpMode != LP_USER) |=> !userSniff)
		else $error("user sniff flag stuck");
	// The stored set must never break the period limits
	a_offset_limit: assert property ({1'b0, sniffCfg.offset} + 17'h0_0002 <= {1'b0, sniffCfg.period})
		else $error("offset above period minus two");
	a_attempt_limit: assert property ({sniffCfg.attempt, 1'b0} < {1'b0, sniffCfg.period})
		else $error("attempt not below half period");
	a_local_drop: assert property (s_cfg_move |-> linkDrop || remoteCfg)
		else $error("local change kept the link");
	a_drop_cause: assert property (linkDrop |-> !remoteCfg && ($changed(lpMode) || $changed(sniffCfg)))
		else $error("link dropped without local change");
	a_drop_pulse: assert property (linkDrop |=> !linkDrop)
		else $error("link drop longer than a cycle");
	// Format may change only in the cycle after a reply byte has been taken
	a_fmt_hold: assert property ($changed(serFmt) |-> $past(txValid && txReady))
		else $error("format changed before reply end");
	a_reply_hold: assert property (s_offer |=> txValid)
		else $error("reply withdrawn before taken");
endmodule : lp_sniff_assertions
`default_nettype wire

// [verification/host_term.sv]
// Purpose: Host terminal model sending text commands and taking replies.
// Assumes: One byte per cycle; a one-cycle gap after each reply handshake.
// Notes:   A released command bus shows the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module host_term (
	// Clock
	input  wire logic       clk,
	// Command bytes
	output var  logic [7:0] rxData,
	output var  logic       rxValid,
	// Reply bytes
	input  wire logic [7:0] txData,
	input  wire logic       txValid,
	output var  logic       txReady
);
	// Idle levels at time zero
	initial begin
		rxData  = 8'h00;
		rxValid = 1'b0;
		txReady = 1'b0;
	end

	////////////////////////////////////////
	// one command at a time
	task automatic cmd(input string s, output logic [63:0] rep);
		int n;
		rep = '0;
		n   = 0;
		foreach (s[i]) begin
			@(negedge clk);
			rxData  = s[i];
			rxValid = 1'b1;
		end
		@(negedge clk);
		rxValid = 1'b0;
		rxData  = ~rxData; // No stale byte on a released bus
		while (!txValid && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk); // Reply byte settles a cycle late
		while (txValid && n < 100) begin
			rep     = {rep[55:0], txData};
			txReady = 1'b1;
			@(negedge clk);
			txReady = 1'b0;
			@(negedge clk);
			n++;
		end
	endtask : cmd
endmodule : host_term
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench for the low-power and sniff configuration bank.
// Assumes: Host model speaks the text command protocol.
// Notes:   Replies are compared right-aligned in 64 bits.
`timescale 1ns/1ps
`default_nettype none
module tb
	import lp_sniff_pkg::*;
;
	localparam logic [63:0] OK = 64'h0000_0000_4F4B_0D0A;
	localparam logic [63:0] ER = 64'h0045_5252_4F52_0D0A;
	localparam sniff_t      DEF = '{16'h0320, 16'h0050, 16'h0008, 16'h0008};

	logic        clk, srst, rxValid, remoteCfg, txValid, txReady, userSniff, linkDrop;
	logic [7:0]  rxData, txData;
	logic [63:0] rep;
	lp_mode_t    lpMode;
	sniff_t      sniffCfg;
	ser_fmt_t    serFmt;
	int          num_errors, n_tests, drops, cycles;

	////////////////////////////////////////
	low_power_sniff_config_regs u_dut (.clk(clk), .srst(srst), .rxData(rxData), .rxValid(rxValid),
		.remoteCfg(remoteCfg), .txData(txData), .txValid(txValid), .txReady(txReady), .lpMode(lpMode),
		.userSniff(userSniff), .sniffCfg(sniffCfg), .serFmt(serFmt), .linkDrop(linkDrop));
	host_term u_host (.clk(clk), .rxData(rxData), .rxValid(rxValid), .txData(txData),
		.txValid(txValid), .txReady(txReady));

	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Link drop pulses and a hang limit
	always @(posedge clk) begin
		cycles <= cycles + 1;
		drops  <= srst ? 0 : drops + int'(linkDrop === 1'b1);
		if (cycles == 8000) begin
			num_errors++;
			end_sim();
		end
	end

	////////////////////////////////////////
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input int r, input int v, input logic [63:0] exp);
		u_host.cmd($sformatf("ATS%0d=%0d\r", r, v), rep);
		chk("write reply", exp, rep);
	endtask : wr

	task automatic rd(input int r, input logic [63:0] exp);
		u_host.cmd($sformatf("ATS%0d?\r", r), rep);
		chk("read reply", exp, rep);
	endtask : rd

	task automatic end_sim;
		$display("errors %0d, checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	////////////////////////////////////////
	// Main sequence
	initial begin
		num_errors = 0;
		n_tests    = 0;
		cycles     = 0;
		drops      = 0;
		srst       = 1'b1;
		remoteCfg  = 1'b0;
		repeat (16) @(negedge clk);
		srst = 1'b0;
		rd(231, "800\r\n");
		rd(232, "80\r\n");
		rd(233, "8\r\n");
		rd(234, "8\r\n");
		chk("sniffCfg", DEF, sniffCfg);
		// Every mode code, user mode last but one
		for (int m = 1; m <= 5; m++) begin
			wr(230, m % 5, OK);
			chk("lpMode", 64'(m % 5), 64'(lpMode));
			chk("userSniff", 64'(m == 4), 64'(userSniff));
		end
		wr(230, 5, ER);
		chk("drops", 5, 64'(drops));
		// Limits one step past and exactly on the boundary
		wr(232, 799, ER);
		wr(233, 400, ER);
		chk("sniffCfg", DEF, sniffCfg);
		wr(232, 798, OK);
		wr(233, 399, OK);
		wr(234, 12, OK);
		rd(234, "12\r\n");
		wr(231, 797, ER);
		chk("drops", 8, 64'(drops));
		remoteCfg = 1'b1;
		wr(231, 1000, OK);
		rd(231, "1000\r\n");
		chk("drops", 8, 64'(drops));
		remoteCfg = 1'b0;
		rd(299, ER);
		wr(210, 5, OK);
		chk("rate", 5, 64'(serFmt.rate));
		wr(230, 3, OK);
		u_host.cmd("AT&F\r", rep);
		chk("restore reply", OK, rep);
		chk("rate", 4, 64'(serFmt.rate));
		chk("sniffCfg", DEF, sniffCfg);
		chk("lpMode", 0, 64'(lpMode));
		chk("drops", 10, 64'(drops));
		// Odd period leaves room for an attempt of exactly half rounded down
		wr(231, 801, OK);
		wr(233, 400, OK);
		wr(231, 70000, ER);
		chk("sniffCfg", {16'h0321, 16'h0050, 16'h0190, 16'h0008}, sniffCfg);
		chk("drops", 12, 64'(drops));
		// Serial format codes outside their ranges and one legal change
		wr(210, 9, ER);
		wr(211, 7, ER);
		wr(213, 3, ER);
		wr(212, 3, OK);
		chk("parity", 3, 64'(serFmt.parity));
		rd(212, "3\r\n");
		chk("drops", 12, 64'(drops));
		// Unknown command letter
		u_host.cmd("ATX\r", rep);
		chk("bad reply", ER, rep);
		end_sim();
	end
endmodule : tb

bind low_power_sniff_config_regs lp_sniff_assertions u_chk (.clk(clk), .srst(srst), .rxData(rxData),
	.rxValid(rxValid), .remoteCfg(remoteCfg), .txData(txData), .txValid(txValid), .txReady(txReady),
	.lpMode(lpMode), .userSniff(userSniff), .sniffCfg(sniffCfg), .serFmt(serFmt), .linkDrop(linkDrop));
`default_nettype wire
